// File: rtl/ppo_params.svh
`ifndef PPO_PARAMS_SVH
`define PPO_PARAMS_SVH
// Contract
// - in deep sleep modes each pin's digital input is clamped low before the schmitt.
// - clamp skips pins whose external interrupt request is enabled, else applies.
// - any-change pin held high, interrupt disabled, flags on wake from clamping sleep.
// - pull-up override off: pull-up on only when dir, outval, kill equal 0b010.
// - pull-up override on: pull-up follows override value, ignoring dir, outval, kill.
// - direction override on: driver enable follows override value, else direction bit.
// - driven value is outval override value when enabled, else the outval bit.
// - input-enable override on: input enable follows override value, else sleep state.
// - raw input taken after schmitt, before synchronizer; consumers synchronise it themselves.
// - analog path connects straight to the pad in both directions; the port only copies pad_in to analog_pad_link.
// - sleep clamp, clock and pull-up kill are shared; other overrides per pin.
// - without override, pin is output when direction bit is one, driving outval.
// - global pull-up kill, bit 2 of control register, turns off all pull-ups not under pull-up override.
// - pin input bit passes a two-stage synchronizer, readable whatever the direction.

// ****************************************
// widths
// ****************************************
`define PPO_PINS        8
`define PPO_AW          8

// ****************************************
// register byte offsets
// ****************************************
`define PPO_ADDR_DIR    8'h00
`define PPO_ADDR_OUTVAL 8'h04
`define PPO_ADDR_PIN    8'h08
`define PPO_ADDR_CTRL   8'h0C
`define PPO_ADDR_STAT   8'h10
`define PPO_ADDR_CLR    8'h14
`define PPO_ADDR_IEN    8'h18
`define PPO_ADDR_SENSE  8'h1C

// ****************************************
// fields and reset values
// ****************************************
`define PPO_CTRL_KILL_BIT 2
`define PPO_RST_BYTE    8'h00
`define PPO_RESP_OKAY   2'h0
`define PPO_RESP_SLVERR 2'h2
`endif

// File: rtl/ppo_pkg.sv
`include "ppo_params.svh"
package ppo_pkg;
	// whole state of the port block, registered by one process
	typedef struct packed {
		logic [`PPO_PINS-1:0] dir;
		logic [`PPO_PINS-1:0] outval;
		logic                 kill;
		logic [`PPO_PINS-1:0] irq_en;
		logic [`PPO_PINS-1:0] sense;
		logic [`PPO_PINS-1:0] status;
		logic [`PPO_PINS-1:0] sync1;
		logic [`PPO_PINS-1:0] sync2;
		logic [`PPO_PINS-1:0] last;
		logic                 aw_got;
		logic                 w_got;
		logic [`PPO_AW-1:0]   awaddr;
		logic [7:0]           wdata;
		logic                 wstrb0;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [7:0]           rdata;
		logic [1:0]           rresp;
	} ppo_state_t;
endpackage

// File: rtl/ppo_pin_cell.sv
// ****************************************
// one pin: override muxing, sleep clamp and input path
// ****************************************
module ppo_pin_cell
	import ppo_pkg::*;
(
	input  wire logic dir_bit,
	input  wire logic outval_bit,
	input  wire logic global_pullup_kill,
	input  wire logic sleep_clamp,
	input  wire logic pullup_ovr_en,
	input  wire logic pullup_ovr_val,
	input  wire logic dir_ovr_en,
	input  wire logic dir_ovr_val,
	input  wire logic outval_ovr_en,
	input  wire logic outval_ovr_val,
	input  wire logic inen_ovr_en,
	input  wire logic inen_ovr_val,
	input  wire logic pad_in,
	output logic      drv_en,
	output logic      drv_val,
	output logic      pullup_en,
	output logic      din
);
	logic in_enable;

	// pull-up: gpio combination 0b010 unless overridden
	assign pullup_en = pullup_ovr_en ? pullup_ovr_val
	                                 : (!dir_bit && outval_bit && !global_pullup_kill);
	// driver enable and driven level
	assign drv_en  = dir_ovr_en ? dir_ovr_val : dir_bit;
	assign drv_val = outval_ovr_en ? outval_ovr_val : outval_bit;
	// input enable: sleep clamp unless overridden, clamp forces low
	assign in_enable = inen_ovr_en ? inen_ovr_val : !sleep_clamp;
	assign din       = pad_in && in_enable;
endmodule

// File: rtl/ppo_port.sv
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`include "ppo_params.svh"
// ****************************************
// port of pins with alternate-function override and axi4-lite registers
// ****************************************
module ppo_port
	import ppo_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	// shared sleep state from the sleep controller
	input  wire logic                 deep_sleep,
	// per-pin overrides from peripheral modules
	input  wire logic [`PPO_PINS-1:0] pullup_ovr_en,
	input  wire logic [`PPO_PINS-1:0] pullup_ovr_val,
	input  wire logic [`PPO_PINS-1:0] dir_ovr_en,
	input  wire logic [`PPO_PINS-1:0] dir_ovr_val,
	input  wire logic [`PPO_PINS-1:0] outval_ovr_en,
	input  wire logic [`PPO_PINS-1:0] outval_ovr_val,
	input  wire logic [`PPO_PINS-1:0] inen_ovr_en,
	input  wire logic [`PPO_PINS-1:0] inen_ovr_val,
	output logic      [`PPO_PINS-1:0] alt_raw_input,
	output logic      [`PPO_PINS-1:0] analog_pad_link,
	// pad side
	input  wire logic [`PPO_PINS-1:0] pad_in,
	output logic      [`PPO_PINS-1:0] pad_out,
	output logic      [`PPO_PINS-1:0] pad_oe_n,
	output logic      [`PPO_PINS-1:0] pad_pullup,
	// interrupt
	output logic                      irq,
	// axi4-lite slave
	input  wire logic [`PPO_AW-1:0]   s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [`PPO_AW-1:0]   s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	ppo_state_t           st;
	ppo_state_t           next_st;
	logic [`PPO_PINS-1:0] drv_en;
	logic [`PPO_PINS-1:0] drv_val;
	logic [`PPO_PINS-1:0] pullup_en;
	logic [`PPO_PINS-1:0] sleep_clamp;
	logic [`PPO_PINS-1:0] change;
	logic [`PPO_PINS-1:0] clr_mask;
	logic                 aw_hs;
	logic                 w_hs;
	logic                 ar_hs;
	logic                 do_write;
	logic [`PPO_AW-1:0]   waddr;
	logic [7:0]           wbyte;
	logic                 wlane;

	// ****************************************
	// pin cells
	// ****************************************

	// shared clamp gated per pin by its external interrupt request
	assign sleep_clamp = {`PPO_PINS{deep_sleep}} & ~st.irq_en;

	// one cell per pin; unused override enables are tied low by the integrator
	genvar gi;
	generate
		for (gi = 0; gi < `PPO_PINS; gi++) begin : g_pin
			ppo_pin_cell u_cell (
				.dir_bit            (st.dir[gi]),
				.outval_bit         (st.outval[gi]),
				.global_pullup_kill (st.kill),
				.sleep_clamp        (sleep_clamp[gi]),
				.pullup_ovr_en      (pullup_ovr_en[gi]),
				.pullup_ovr_val     (pullup_ovr_val[gi]),
				.dir_ovr_en         (dir_ovr_en[gi]),
				.dir_ovr_val        (dir_ovr_val[gi]),
				.outval_ovr_en      (outval_ovr_en[gi]),
				.outval_ovr_val     (outval_ovr_val[gi]),
				.inen_ovr_en        (inen_ovr_en[gi]),
				.inen_ovr_val       (inen_ovr_val[gi]),
				.pad_in             (pad_in[gi]),
				.drv_en             (drv_en[gi]),
				.drv_val            (drv_val[gi]),
				.pullup_en          (pullup_en[gi]),
				.din                (alt_raw_input[gi])
			);
		end
	endgenerate

	// pad drive: oe_n low while driving, otherwise released (hi-z unless pulled)
	assign pad_out         = drv_val;
	assign pad_oe_n        = ~drv_en;
	assign pad_pullup      = pullup_en;
	// analog path sees the pad level with no digital gating
	assign analog_pad_link = pad_in;

	// ****************************************
	// bus handshakes
	// ****************************************

	// address and data accepted independently, one write in flight
	assign s_axi_awready = !st.aw_got && !st.bvalid;
	assign s_axi_wready  = !st.w_got && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign aw_hs         = s_axi_awvalid && s_axi_awready;
	assign w_hs          = s_axi_wvalid && s_axi_wready;
	assign ar_hs         = s_axi_arvalid && s_axi_arready;

	// the write happens once both halves are present
	assign waddr    = aw_hs ? s_axi_awaddr : st.awaddr;
	assign wbyte    = w_hs ? s_axi_wdata[7:0] : st.wdata;
	assign wlane    = w_hs ? s_axi_wstrb[0] : st.wstrb0;
	assign do_write = (st.aw_got || aw_hs) && (st.w_got || w_hs) && !st.bvalid;

	// response outputs straight from state
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp  = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rresp  = st.rresp;
	assign s_axi_rdata  = {24'h000000, st.rdata};

	// ****************************************
	// interrupt events
	// ****************************************

	// any change of the synchronised level on pins set for any-change sensing
	assign change   = (st.sync2 ^ st.last) & st.sense;
	assign clr_mask = (do_write && wlane && waddr[`PPO_AW-1:2] == `PPO_ADDR_CLR >> 2) ? wbyte : `PPO_RST_BYTE;
	assign irq      = |(st.status & st.irq_en);

	// ****************************************
	// next state
	// ****************************************

	// all register, synchroniser and bus updates
	always_comb begin
		next_st = st;
		// two-stage synchroniser, readable whatever the direction
		next_st.sync1  = alt_raw_input;
		next_st.sync2  = st.sync1;
		next_st.last   = st.sync2;
		// set wins over a clear in the same cycle
		next_st.status = (st.status & ~clr_mask) | change;

		// write channel capture
		if (aw_hs) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (w_hs) begin
			next_st.w_got  = 1'b1;
			next_st.wdata  = s_axi_wdata[7:0];
			next_st.wstrb0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = `PPO_RESP_OKAY;
			case ({waddr[`PPO_AW-1:2], 2'b00})
				`PPO_ADDR_DIR: begin
					if (wlane) next_st.dir = wbyte;
				end
				`PPO_ADDR_OUTVAL: begin
					if (wlane) next_st.outval = wbyte;
				end
				`PPO_ADDR_CTRL: begin
					if (wlane) next_st.kill = wbyte[`PPO_CTRL_KILL_BIT];
				end
				`PPO_ADDR_IEN: begin
					if (wlane) next_st.irq_en = wbyte;
				end
				`PPO_ADDR_SENSE: begin
					if (wlane) next_st.sense = wbyte;
				end
				`PPO_ADDR_PIN, `PPO_ADDR_STAT, `PPO_ADDR_CLR: begin
					next_st.bresp = `PPO_RESP_OKAY;
				end
				default: begin
					next_st.bresp = `PPO_RESP_SLVERR;
				end
			endcase
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// read channel
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (ar_hs) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = `PPO_RESP_OKAY;
			case ({s_axi_araddr[`PPO_AW-1:2], 2'b00})
				`PPO_ADDR_DIR:    next_st.rdata = st.dir;
				`PPO_ADDR_OUTVAL: next_st.rdata = st.outval;
				`PPO_ADDR_PIN:    next_st.rdata = st.sync2;
				`PPO_ADDR_CTRL:   next_st.rdata = {5'h00, st.kill, 2'h0};
				`PPO_ADDR_STAT:   next_st.rdata = st.status;
				`PPO_ADDR_CLR:    next_st.rdata = `PPO_RST_BYTE;
				`PPO_ADDR_IEN:    next_st.rdata = st.irq_en;
				`PPO_ADDR_SENSE:  next_st.rdata = st.sense;
				default: begin
					next_st.rdata = `PPO_RST_BYTE;
					next_st.rresp = `PPO_RESP_SLVERR;
				end
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************

	// synchronous active-low reset to constants
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// checks
	// ****************************************

	// gpio pull-up only for 0b010 where not overridden
	a_pullup_gpio:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		((~pullup_ovr_en) & (pad_pullup ^ (~st.dir & st.outval & {`PPO_PINS{~st.kill}}))) == '0)
	else $error("pull-up differs from gpio combination");

	// override value rules the pull-up
	a_pullup_ovr:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(pullup_ovr_en & (pad_pullup ^ pullup_ovr_val)) == '0)
	else $error("pull-up ignores override value");

	// kill switches off every pull-up while no pin is overridden, even after a change of dir
	a_kill_pullups:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		st.kill && pullup_ovr_en == '0 |-> pad_pullup == '0 ##1 (!st.kill || pad_pullup == '0 || pullup_ovr_en != '0))
	else $error("pull-up on while kill set");

	// driver enable from override or direction bit
	a_drive_enable:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(~pad_oe_n) == ((dir_ovr_en & dir_ovr_val) | (~dir_ovr_en & st.dir)))
	else $error("driver enable wrong");

	// driven value where the driver is on
	a_drive_value:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(~pad_oe_n & (pad_out ^ ((outval_ovr_en & outval_ovr_val) | (~outval_ovr_en & st.outval)))) == '0)
	else $error("driven value wrong");

	// clamped pins show a low raw input in deep sleep
	a_sleep_clamp:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		deep_sleep |-> ((~inen_ovr_en & ~st.irq_en & alt_raw_input) == '0))
	else $error("raw input not clamped in sleep");

	// enabled interrupt pins and forced-on inputs see the pad
	a_input_pass:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(((inen_ovr_en & inen_ovr_val) | (~inen_ovr_en & st.irq_en)) & (alt_raw_input ^ pad_in)) == '0)
	else $error("raw input blocked");

	// pin register is the raw input two edges later
	a_sync_delay:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		##2 st.sync2 == $past(alt_raw_input, 2))
	else $error("synchroniser delay wrong");

	// a sensed change sets its flag next cycle, even during a clear
	a_flag_set:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		change != '0 |=> (st.status & $past(change)) == $past(change))
	else $error("change flag lost");

	// no output drive and no pull-up leaves the pad floating
	a_pad_float:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(pad_oe_n & ~pad_pullup & ~(~dir_ovr_en & st.dir) & ~(dir_ovr_en & dir_ovr_val)) == (pad_oe_n & ~pad_pullup))
	else $error("pad drive state inconsistent");

	// write response one cycle after both halves arrive
	a_write_answer:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		do_write |=> st.bvalid)
	else $error("write response missing");

	// read data one cycle after the address
	a_read_answer:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		ar_hs |=> st.rvalid && !s_axi_arready)
	else $error("read response missing");

	// analog path is the bare pad level
	a_analog_path:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		analog_pad_link == pad_in)
	else $error("analog path not tied to pad");

	// kill bit takes its bit of a control write
	a_kill_write:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		do_write && wlane && waddr[`PPO_AW-1:2] == `PPO_ADDR_CTRL >> 2
		|=> st.kill == $past(wbyte[`PPO_CTRL_KILL_BIT]))
	else $error("kill bit not written");

	// a cleared flag with no new change is gone next cycle
	a_flag_clear:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		clr_mask != '0 && (clr_mask & change) == '0 |=> (st.status & $past(clr_mask)) == '0)
	else $error("flag not cleared");

	// a set flag stays until a clear is written
	a_flag_sticky:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		(st.status & ~clr_mask) != '0 |=> ($past(st.status) & ~$past(clr_mask) & ~st.status) == '0)
	else $error("flag dropped without clear");

	// unmapped write answered with an error
	a_write_error:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		do_write && waddr[`PPO_AW-1:5] != '0 |=> s_axi_bresp == `PPO_RESP_SLVERR)
	else $error("unmapped write not refused");

	// unmapped read answered with an error and zero data
	a_read_error:
	assert property (@(posedge sys_clk) disable iff (!resetn)
		ar_hs && s_axi_araddr[`PPO_AW-1:5] != '0 |=> s_axi_rresp == `PPO_RESP_SLVERR && s_axi_rdata == '0)
	else $error("unmapped read not refused");
endmodule

// File: bench/ppo_periph_model.sv
`include "ppo_params.svh"
// ****************************************
// peripheral side: override sources and a consumer synchroniser
// ****************************************
module ppo_periph_model
	import ppo_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	input  wire logic                 load,
	input  wire logic [63:0]          pattern,
	input  wire logic [`PPO_PINS-1:0] alt_raw_input,
	output logic      [`PPO_PINS-1:0] pullup_ovr_en,
	output logic      [`PPO_PINS-1:0] pullup_ovr_val,
	output logic      [`PPO_PINS-1:0] dir_ovr_en,
	output logic      [`PPO_PINS-1:0] dir_ovr_val,
	output logic      [`PPO_PINS-1:0] outval_ovr_en,
	output logic      [`PPO_PINS-1:0] outval_ovr_val,
	output logic      [`PPO_PINS-1:0] inen_ovr_en,
	output logic      [`PPO_PINS-1:0] inen_ovr_val,
	output logic      [`PPO_PINS-1:0] raw_synced
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [`PPO_PINS-1:0] sync_a;
	// each owning module makes its override pairs from its own flops
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			{pullup_ovr_en, pullup_ovr_val, dir_ovr_en, dir_ovr_val,
				outval_ovr_en, outval_ovr_val, inen_ovr_en, inen_ovr_val} <= '0; // plain gpio after reset
		end else if (load) begin
			{pullup_ovr_en, pullup_ovr_val, dir_ovr_en, dir_ovr_val,
				outval_ovr_en, outval_ovr_val, inen_ovr_en, inen_ovr_val} <= pattern;
		end
	end
	// the consumer resamples the raw input before use
	always_ff @(posedge sys_clk) begin
		sync_a <= alt_raw_input;
		raw_synced <= sync_a;
	end
endmodule

// File: bench/tb_top.sv
`include "ppo_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
// ****************************************
// self-checking bench for the port block
// ****************************************
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ppo_pkg::*;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        deep_sleep = 1'b0;
	logic        load = 1'b0;
	logic [63:0] pattern = '0;
	logic [7:0]  ext_val = 8'h00;
	logic [7:0]  pullup_ovr_en, pullup_ovr_val, dir_ovr_en, dir_ovr_val;
	logic [7:0]  outval_ovr_en, outval_ovr_val, inen_ovr_en, inen_ovr_val;
	logic [7:0]  alt_raw_input, analog_pad_link, pad_in, pad_out, pad_oe_n, pad_pullup, raw_synced;
	logic        irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0;
	logic [2:0]  s_axi_arprot = 3'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, d;
	logic [1:0]  r;
	logic [7:0]  dir_r, out_r, ien_r, c;
	logic        kill_r;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          cycles = 0;

	// pad wire: the block drives it when enabled, the outside world otherwise
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_val);

	ppo_port DUT (.sys_clk, .resetn, .deep_sleep, .pullup_ovr_en, .pullup_ovr_val, .dir_ovr_en, .dir_ovr_val,
		.outval_ovr_en, .outval_ovr_val, .inen_ovr_en, .inen_ovr_val, .alt_raw_input, .analog_pad_link,
		.pad_in, .pad_out, .pad_oe_n, .pad_pullup, .irq, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	ppo_periph_model PM (.sys_clk, .resetn, .load, .pattern, .alt_raw_input, .pullup_ovr_en, .pullup_ovr_val,
		.dir_ovr_en, .dir_ovr_val, .outval_ovr_en, .outval_ovr_val, .inen_ovr_en, .inen_ovr_val, .raw_synced);

	// clock and hang guard
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			error_cnt++;
			test_done();
		end
	end

	// expected {pull-up, oe_n, raw input} from the settings
	function automatic logic [23:0] exp_pad(input logic [63:0] p, input logic [7:0] dr, input logic [7:0] o,
		input logic k, input logic [7:0] ie_r, input logic ds, input logic [7:0] ext, input logic [7:0] ov);
		logic [7:0] pu, drv, in_en;
		pu = (p[63:56] & p[55:48]) | (~p[63:56] & ~dr & o & ~{8{k}});
		drv = (p[47:40] & p[39:32]) | (~p[47:40] & dr);
		in_en = (p[15:8] & p[7:0]) | (~p[15:8] & ~({8{ds}} & ~ie_r));
		return {pu, ~drv, ((drv & ov) | (~drv & ext)) & in_en};
	endfunction

	// compare every pad-side output with the expectation
	task automatic check_pads();
		logic [23:0] e;
		logic [7:0]  ov;
		ov = (pattern[31:24] & pattern[23:16]) | (~pattern[31:24] & out_r);
		e = exp_pad(pattern, dir_r, out_r, kill_r, ien_r, deep_sleep, ext_val, ov);
		`CHK(pad_pullup, e[23:16])
		`CHK(pad_oe_n, e[15:8])
		`CHK(pad_out & ~e[15:8], ov & ~e[15:8])
		`CHK(alt_raw_input, e[7:0])
		`CHK(analog_pad_link, pad_in)
	endtask

	// one write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask

	// one read
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		v = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{dir_r, out_r, ien_r, kill_r} = '0;
		void'($urandom(22408));
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		// reset values, then unmapped places
		for (int a = 0; a < 8; a++) begin
			rd(8'(a * 4), d, r);
			`CHK({r, d}, {`PPO_RESP_OKAY, 32'h0})
		end
		#1 check_pads();
		rd(8'h20, d, r);
		`CHK({r, d}, {`PPO_RESP_SLVERR, 32'h0})
		wr(8'h24, 32'hFF, `PPO_RESP_SLVERR);
		// a write with byte lane 0 off changes nothing
		s_axi_wstrb <= 4'hE;
		wr(`PPO_ADDR_DIR, 32'hFF, `PPO_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(`PPO_ADDR_DIR, d, r);
		`CHK(d, 32'h0)
		// random settings, with all-off and all-on overrides first
		for (int i = 0; i < 40; i++) begin
			dir_r = 8'($urandom);
			out_r = 8'($urandom);
			ien_r = 8'($urandom);
			c = 8'($urandom);
			kill_r = c[`PPO_CTRL_KILL_BIT];
			wr(`PPO_ADDR_DIR, {24'h0, dir_r}, `PPO_RESP_OKAY);
			wr(`PPO_ADDR_OUTVAL, {24'h0, out_r}, `PPO_RESP_OKAY);
			wr(`PPO_ADDR_CTRL, {24'h0, c}, `PPO_RESP_OKAY);
			wr(`PPO_ADDR_IEN, {24'h0, ien_r}, `PPO_RESP_OKAY);
			@(posedge sys_clk);
			pattern <= (i == 0) ? 64'h0 : (i == 1) ? '1 : {$urandom, $urandom};
			ext_val <= 8'($urandom);
			deep_sleep <= 1'($urandom);
			load <= 1'b1;
			@(posedge sys_clk);
			load <= 1'b0;
			@(posedge sys_clk);
			#1 check_pads();
			repeat (3) @(posedge sys_clk);
			#1 `CHK(raw_synced, alt_raw_input)
			rd(`PPO_ADDR_PIN, d, r);
			`CHK(d, {24'h0, alt_raw_input})
			`CHK(irq, 1'b0)
		end
		// clamp on sleep makes an edge on a high any-change pin
		{dir_r, out_r, ien_r, kill_r} = '0;
		@(posedge sys_clk);
		pattern <= '0;
		load <= 1'b1;
		ext_val <= 8'h01;
		deep_sleep <= 1'b0;
		@(posedge sys_clk);
		load <= 1'b0;
		for (int a = 0; a < 4; a++) wr(8'(a * 4), 32'h0, `PPO_RESP_OKAY);
		wr(`PPO_ADDR_IEN, 32'h0, `PPO_RESP_OKAY);
		wr(`PPO_ADDR_SENSE, 32'h1, `PPO_RESP_OKAY);
		repeat (5) @(posedge sys_clk);
		wr(`PPO_ADDR_CLR, 32'hFF, `PPO_RESP_OKAY);
		rd(`PPO_ADDR_STAT, d, r);
		`CHK(d, 32'h0)
		@(posedge sys_clk);
		deep_sleep <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 `CHK(alt_raw_input[0], 1'b0)
		// drop the flag from entering sleep so only the wake edge can set it
		wr(`PPO_ADDR_CLR, 32'hFF, `PPO_RESP_OKAY);
		rd(`PPO_ADDR_STAT, d, r);
		`CHK(d, 32'h0)
		@(posedge sys_clk);
		deep_sleep <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rd(`PPO_ADDR_STAT, d, r);
		`CHK(d, 32'h1)
		`CHK(irq, 1'b0)
		// unmask, then clear
		wr(`PPO_ADDR_IEN, 32'h1, `PPO_RESP_OKAY);
		#1 `CHK(irq, 1'b1)
		wr(`PPO_ADDR_CLR, 32'h1, `PPO_RESP_OKAY);
		#1 `CHK(irq, 1'b0)
		// enabled interrupt pin is exempt from the clamp
		ien_r = 8'h01;
		@(posedge sys_clk);
		deep_sleep <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 `CHK(alt_raw_input, 8'h01)
		rd(`PPO_ADDR_STAT, d, r);
		`CHK({d, irq}, 33'h0)
		test_done();
	end
endmodule
